// ==== rtl/ebp_pkg.sv ====
// Package of constants and types for the external bus cycle phase sequencer.
package ebp_pkg;

  // ==========================================================================
  // Phase state encoding
  typedef enum logic [2:0] {
    EBP_IDLE = 3'b000,
    EBP_AB = 3'b001,
    EBP_C = 3'b010,
    EBP_D = 3'b011,
    EBP_E = 3'b100,
    EBP_F = 3'b101
  } ebp_state_t;

  // ==========================================================================
  // Field positions inside chip_select_timing_ctrl
  localparam int AB_POS = 0;
  localparam int AB_W = 1;
  localparam int ABX_POS = 1;
  localparam int ABX_W = 2;
  localparam int C_POS = 3;
  localparam int C_W = 2;
  localparam int D_POS = 5;
  localparam int E_POS = 6;
  localparam int E_W = 5;
  localparam int F_POS = 11;
  localparam int F_W = 2;
  localparam int RDY_POS = 13;
  localparam int TCTRL_W = 14;

  // ==========================================================================
  // Reset values, chip select count and timebase
  localparam logic [TCTRL_W-1:0] TCTRL_RST = 14'h0000;
  localparam int CS_NUM = 4;
  localparam int TICK_DIV = 2;
  localparam logic [4:0] CNT_RST = 5'h00;

endpackage

// ==== rtl/ebp_tick.sv ====
// Bus phase timebase divider producing one pulse per bus time unit.
`timescale 1ns/1ps
module ebp_tick #(
  parameter int DIV = ebp_pkg::TICK_DIV
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  output logic tick
);

  logic [7:0] cnt_q, cnt_d;
  logic tick_d;

  // The tick is not registered, so the first unit of a phase is as long as the others.
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!run) begin
      cnt_d = 8'h00;
    end else if (cnt_q == 8'(DIV - 1)) begin
      cnt_d = 8'h00;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  assign tick = tick_d;

endmodule

// ==== rtl/ebp_seq.sv ====
// External bus cycle phase sequencer with per chip select timing.
// Functional notes
// - Each cycle runs address setup, command delay, data setup, access, hold in order.
// - Phase lengths come from per chip select timing control; command delay 0 to 3.
// - Address setup lasts 1 or 2 units, plus 0 to 3 on window change.
// - Write data setup or tristate phase lasts 0 or 1 unit.
// - Access lasts 1 to 32 units; ready input may extend it when enabled.
// - Address and write data hold phase lasts 0 to 3 units.
`timescale 1ns/1ps
module ebp_seq #(
  parameter int NCS = ebp_pkg::CS_NUM,
  parameter int DIV = ebp_pkg::TICK_DIV
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input wire logic [1:0] cs_sel,
  input wire logic [NCS*ebp_pkg::TCTRL_W-1:0] chip_select_timing_ctrl,
  input wire logic ready_in,
  output logic busy,
  output logic [2:0] phase,
  output logic phase_ab,
  output logic phase_c,
  output logic phase_d,
  output logic phase_e,
  output logic phase_f,
  output logic done
);

  // ==========================================================================
  // Helpers
  function automatic logic [4:0] len_of(input ebp_pkg::ebp_state_t s,
                                        input logic [ebp_pkg::TCTRL_W-1:0] t,
                                        input logic win_chg);
    logic [4:0] l;
    l = 5'h00;
    case (s)
      ebp_pkg::EBP_AB: begin
        l = 5'(t[ebp_pkg::AB_POS]) + 5'h01;
        if (win_chg) begin
          l = l + 5'(t[ebp_pkg::ABX_POS +: ebp_pkg::ABX_W]);
        end
      end
      ebp_pkg::EBP_C: l = 5'(t[ebp_pkg::C_POS +: ebp_pkg::C_W]);
      ebp_pkg::EBP_D: l = 5'(t[ebp_pkg::D_POS]);
      ebp_pkg::EBP_E: l = t[ebp_pkg::E_POS +: ebp_pkg::E_W];
      ebp_pkg::EBP_F: l = 5'(t[ebp_pkg::F_POS +: ebp_pkg::F_W]);
      default: l = 5'h00;
    endcase
    return l;
  endfunction

  // Next phase in fixed order, skipping zero length ones.
  function automatic ebp_pkg::ebp_state_t next_of(input ebp_pkg::ebp_state_t s,
                                                 input logic [ebp_pkg::TCTRL_W-1:0] t);
    ebp_pkg::ebp_state_t n;
    n = ebp_pkg::EBP_IDLE;
    case (s)
      ebp_pkg::EBP_AB: n = ebp_pkg::EBP_C;
      ebp_pkg::EBP_C: n = ebp_pkg::EBP_D;
      ebp_pkg::EBP_D: n = ebp_pkg::EBP_E;
      ebp_pkg::EBP_E: n = ebp_pkg::EBP_F;
      default: n = ebp_pkg::EBP_IDLE;
    endcase
    if (n == ebp_pkg::EBP_C && len_of(n, t, 1'b0) == 5'h00) begin
      n = ebp_pkg::EBP_D;
    end
    if (n == ebp_pkg::EBP_D && len_of(n, t, 1'b0) == 5'h00) begin
      n = ebp_pkg::EBP_E;
    end
    if (n == ebp_pkg::EBP_F && len_of(n, t, 1'b0) == 5'h00) begin
      n = ebp_pkg::EBP_IDLE;
    end
    return n;
  endfunction

  // ==========================================================================
  // State
  ebp_pkg::ebp_state_t st_q, st_d;
  logic [4:0] cnt_q, cnt_d;
  logic [ebp_pkg::TCTRL_W-1:0] tc_q, tc_d;
  logic [1:0] cs_q, cs_d;
  logic cs_vld_q, cs_vld_d;
  logic done_d, done_q;
  logic tick;
  logic [ebp_pkg::TCTRL_W-1:0] tsel;
  logic last_unit;
  logic win_chg;
  logic e_exit;

  // ==========================================================================
  // Timebase
  ebp_tick #(
    .DIV(DIV)
  ) u_tick (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(st_q != ebp_pkg::EBP_IDLE),
    .tick(tick)
  );

  assign tsel = chip_select_timing_ctrl[cs_sel*ebp_pkg::TCTRL_W +: ebp_pkg::TCTRL_W];
  assign last_unit = tick && (cnt_q == 5'h01);
  // A new chip select, or the first cycle after reset, opens a new address window.
  assign win_chg = !cs_vld_q || (cs_q != cs_sel);
  assign e_exit = last_unit && (!tc_q[ebp_pkg::RDY_POS] || ready_in);

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tc_d = tc_q;
    cs_d = cs_q;
    cs_vld_d = cs_vld_q;
    done_d = 1'b0;
    case (st_q)
      ebp_pkg::EBP_IDLE: begin
        if (start) begin
          tc_d = tsel;
          cs_d = cs_sel;
          cs_vld_d = 1'b1;
          st_d = ebp_pkg::EBP_AB;
          cnt_d = len_of(ebp_pkg::EBP_AB, tsel, win_chg);
        end
      end
      ebp_pkg::EBP_E: begin
        if (tick && cnt_q != 5'h01) begin
          cnt_d = cnt_q - 5'h01;
        end else if (e_exit) begin
          st_d = next_of(st_q, tc_q);
          cnt_d = len_of(st_d, tc_q, 1'b0);
          done_d = (st_d == ebp_pkg::EBP_IDLE);
        end
      end
      ebp_pkg::EBP_AB, ebp_pkg::EBP_C, ebp_pkg::EBP_D, ebp_pkg::EBP_F: begin
        if (tick) begin
          if (cnt_q == 5'h01) begin
            st_d = next_of(st_q, tc_q);
            cnt_d = len_of(st_d, tc_q, 1'b0);
            done_d = (st_d == ebp_pkg::EBP_IDLE);
          end else begin
            cnt_d = cnt_q - 5'h01;
          end
        end
      end
      default: st_d = ebp_pkg::EBP_IDLE;
    endcase
  end

  // ==========================================================================
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ebp_pkg::EBP_IDLE;
      cnt_q <= ebp_pkg::CNT_RST;
      tc_q <= ebp_pkg::TCTRL_RST;
      cs_q <= 2'h0;
      cs_vld_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tc_q <= tc_d;
      cs_q <= cs_d;
      cs_vld_q <= cs_vld_d;
      done_q <= done_d;
    end
  end

  // ==========================================================================
  // Registered phase outputs
  logic busy_q, ab_q, c_q, d_q, e_q, f_q;
  logic [2:0] ph_q;
  logic busy_d, ab_d, c_d, d_d, e_d, f_d;
  logic [2:0] ph_d;

  // ==========================================================================
  // Phase output next values
  // Outputs are decoded from the next state so that they line up with the state register.
  always_comb begin
    busy_d = st_d != ebp_pkg::EBP_IDLE;
    ph_d = st_d;
    ab_d = st_d == ebp_pkg::EBP_AB;
    c_d = st_d == ebp_pkg::EBP_C;
    d_d = st_d == ebp_pkg::EBP_D;
    e_d = st_d == ebp_pkg::EBP_E;
    f_d = st_d == ebp_pkg::EBP_F;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_q <= 1'b0;
      ph_q <= 3'h0;
      ab_q <= 1'b0;
      c_q <= 1'b0;
      d_q <= 1'b0;
      e_q <= 1'b0;
      f_q <= 1'b0;
    end else if (ce) begin
      busy_q <= busy_d;
      ph_q <= ph_d;
      ab_q <= ab_d;
      c_q <= c_d;
      d_q <= d_d;
      e_q <= e_d;
      f_q <= f_d;
    end
  end

  assign busy = busy_q;
  assign phase = ph_q;
  assign phase_ab = ab_q;
  assign phase_c = c_q;
  assign phase_d = d_q;
  assign phase_e = e_q;
  assign phase_f = f_q;
  assign done = done_q;

endmodule

// ==== test/ebp_ext.sv ====
// External module model that answers the access phase ready handshake.
`timescale 1ns/1ps
module ebp_ext (
  input wire logic clk,
  input wire logic phase_e,
  output logic ready_in
);
  int wait_q = 0;
  // Ready is held back a random number of clocks at the start of each access.
  always @(posedge clk) begin
    if (!phase_e) wait_q <= $urandom % 4;
    else if (wait_q > 0) wait_q <= wait_q - 1;
  end
  assign ready_in = phase_e && wait_q == 0;
endmodule

// ==== test/ebp_seq_chk.sv ====
// Port assertions for the bus cycle phase sequencer.
`timescale 1ns/1ps
module ebp_seq_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input wire logic busy,
  input wire logic [2:0] phase,
  input wire logic phase_ab,
  input wire logic phase_c,
  input wire logic phase_d,
  input wire logic phase_e,
  input wire logic phase_f,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || !ce);
  // Bounds assume one clock per bus time unit; a frozen clock aborts the attempt.
  sequence s_go; start && ce && !busy; endsequence
  sequence s_next; phase_c || phase_d || phase_e; endsequence
  property p_start; s_go |=> phase_ab && busy; endproperty
  property p_order; $fell(phase_ab) && busy |-> s_next; endproperty
  sequence s_after_e; phase_f || done; endsequence
  property p_ab; $rose(phase_ab) |-> ##[1:5] !phase_ab; endproperty
  property p_c; $rose(phase_c) |-> ##[1:3] !phase_c; endproperty
  property p_d; $rose(phase_d) |-> ##1 !phase_d; endproperty
  property p_e; $rose(phase_e) |-> ##[1:32] !phase_e; endproperty
  property p_f; $rose(phase_f) |-> $past(phase_e) ##[1:3] !phase_f; endproperty
  property p_end; $fell(phase_e) |-> s_after_e; endproperty
  property p_code;
    busy |-> phase == {phase_e || phase_f, phase_c || phase_d, phase_ab || phase_d || phase_f};
  endproperty
  property p_hot;
    busy |-> $onehot({phase_ab, phase_c, phase_d, phase_e, phase_f}) && phase != 3'h0;
  endproperty
  property p_done; $fell(busy) |-> done; endproperty
  a_start: assert property (p_start) else $error("no setup after start");
  a_order: assert property (p_order) else $error("bad phase order");
  a_ab: assert property (p_ab) else $error("setup too long");
  a_c: assert property (p_c) else $error("command delay too long");
  a_d: assert property (p_d) else $error("data setup too long");
  a_e: assert property (p_e) else $error("access too long");
  a_f: assert property (p_f) else $error("hold wrong");
  a_hot: assert property (p_hot) else $error("phase not one-hot");
  a_done: assert property (p_done) else $error("no done at end");
  a_end: assert property (p_end) else $error("bad phase after access");
  a_code: assert property (p_code) else $error("phase code mismatch");
endmodule
bind ebp_seq ebp_seq_chk u_ebp_seq_chk(.clk(clk), .resetn(resetn), .ce(ce), .start(start),
  .busy(busy), .phase(phase), .phase_ab(phase_ab), .phase_c(phase_c), .phase_d(phase_d),
  .phase_e(phase_e), .phase_f(phase_f), .done(done));

// ==== test/external_bus_cycle_phases_tb_top.sv ====
// Self-checking testbench for the bus cycle phase sequencer.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0d got %0d", n, e, s); end end
module external_bus_cycle_phases_tb_top;
  logic clk = 0, resetn = 0, ce = 1, start = 0, ready_in, busy, done;
  logic pab, pc, pd, pe, pf, first = 1, last_rdy = 0;
  logic [1:0] cs_sel = 0, pcs = 0;
  logic [2:0] phase;
  logic [55:0] tctl = 0;
  logic [39:0] q[$];
  int bad_count = 0, n_tests = 0, na = 0, nc = 0, nd = 0, ne = 0, nf = 0;
  always #12.5 clk = ~clk;
  ebp_seq #(.NCS(4), .DIV(1)) u_ebp_seq(.clk(clk), .resetn(resetn), .ce(ce), .start(start),
    .cs_sel(cs_sel), .chip_select_timing_ctrl(tctl), .ready_in(ready_in), .busy(busy),
    .phase(phase), .phase_ab(pab), .phase_c(pc), .phase_d(pd), .phase_e(pe), .phase_f(pf),
    .done(done));
  ebp_ext u_ebp_ext(.clk(clk), .phase_e(pe), .ready_in(ready_in));
  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Counts enabled clocks per phase and compares them when a cycle ends.
  always @(posedge clk) begin : mon
    logic [39:0] x;
    if (done === 1'b1 && ce === 1'b1) begin
      x = q.pop_front();
      `CHK("idle", 4'h0, {busy, phase})
      `CHK("ab", x[39:32], 8'(na))
      `CHK("c", x[31:24], 8'(nc))
      `CHK("d", x[23:16], 8'(nd))
      `CHK("e", 1'b1, x[15] ? ne >= x[13:8] : ne == x[13:8])
      `CHK("rdy", 1'b1, !x[15] || last_rdy)
      `CHK("f", x[7:0], 8'(nf))
      {na, nc, nd, ne, nf} = 0;
    end else if (ce === 1'b1) begin
      if (pe === 1'b1) last_rdy = ready_in;
      na += (pab === 1'b1);
      nc += (pc === 1'b1);
      nd += (pd === 1'b1);
      ne += (pe === 1'b1);
      nf += (pf === 1'b1);
    end
  end
  task run(input logic [1:0] cs);
    logic [13:0] w;
    int ab;
    w = 14'($urandom);
    tctl[cs*14 +: 14] = w;
    ab = 1 + w[0] + ((first || cs != pcs) ? w[2:1] : 0);
    q.push_back({8'(ab), 6'h0, w[4:3], 7'h0, w[5], w[13], 1'b0,
      (w[10:6] == 5'h00) ? 6'h20 : {1'b0, w[10:6]}, 6'h0, w[12:11]});
    cs_sel = cs;
    pcs = cs;
    first = 0;
    ce = 1;
    start = 1;
    @(posedge clk) #1 start = 0;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk) #1;
      if (done === 1'b1) break;
      ce = ($urandom % 4) != 0;
    end
  endtask
  initial begin
    #500000 bad_count++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h3847c817));
    repeat (6) @(posedge clk);
    #1 resetn = 1;
    for (int k = 0; k < 40; k++) begin
      if (k == 20) begin
        resetn = 0;
        first = 1;
        repeat (2) @(posedge clk);
        #1 resetn = 1;
      end
      run(2'($urandom % 4));
    end
    repeat (3) @(posedge clk);
    `CHK("left", 0, q.size())
    end_sim;
  end
endmodule
